//--- common/pmcfg_consts.vh
`ifndef PMCFG_CONSTS_VH
`define PMCFG_CONSTS_VH
// command codes
`define PMCFG_CMD_MISC      8'hD1
`define PMCFG_CMD_GROUP     8'hD3
`define PMCFG_CMD_OKDLY     8'hD4
`define PMCFG_CMD_RAMP      8'hD5
`define PMCFG_CMD_IND       8'hD6
`define PMCFG_CMD_SNAPMASK  8'hD7
// writable bit masks, reserved bits cleared
`define PMCFG_MISC_WMASK    16'hFC87
`define PMCFG_GROUP_WMASK   16'hFF0F
`define PMCFG_SNAP_WMASK    16'h3FFF
// field positions
`define PMCFG_MINDUTY_HI    15
`define PMCFG_MINDUTY_LO    11
`define PMCFG_DRV_EN_BIT    10
`define PMCFG_MINDUTY_EN    7
`define PMCFG_PG_PP_BIT     2
`define PMCFG_XT_EN_BIT     1
`define PMCFG_XT_FLT_BIT    0
`define PMCFG_PHASE_HI      15
`define PMCFG_PHASE_LO      13
`define PMCFG_RAIL_HI       12
`define PMCFG_RAIL_LO       8
`define PMCFG_NPH_HI        3
`define PMCFG_NPH_LO        0
// reset values
`define PMCFG_MISC_RST      16'h0400
`define PMCFG_GROUP_RST     16'h0000
`define PMCFG_OKDLY_RST     16'h0000
`define PMCFG_RAMP_RST      8'h01
`define PMCFG_IND_RST       16'h0000
`define PMCFG_SNAP_RST      16'h0000
// timing
`define PMCFG_CLK_HZ        50000000
`define PMCFG_MS_PER_S      1000
`define PMCFG_OKDLY_MAX_MS  16'h1388
`endif

//--- core/pmcfg_regs.v
`timescale 1ns/1ps
`include "pmcfg_consts.vh"
// Notes on behaviour
// - min on-time is 2*(value+1)/512 period
// - min duty only when bit 7 set
// - bit 10 gates power switch drive
// - bit 2: 0 open-drain, 1 push-pull
// - bit 1 enables external temperature sensor
// - bit 0 picks external sensor for faults
// - rail id 0..31, same across group
// - phase position is bits 14..13 plus one
// - phases field only 1,3,5,7 allowed
// - power-good waits programmed delay after threshold
// - delay rounded to whole millisecond
// - sharing selects shared ramp using gain
// - smaller gain gives longer rise time
// - fast loop off during shared ramp until power-good
// - no soft-off ramp when sharing
// - inductor value range 0..100 microhenry
// - mask bit 1 blocks snapshot trigger
// - bits 13..8 group,phase,cpu,crc,monuv,monov
// - bits 7..0 uc,oc,vinuv,vinov,ut,ot,vuv,vov
module pmcfg_regs #(
    parameter CYC_PER_MS = `PMCFG_CLK_HZ / `PMCFG_MS_PER_S,
    parameter IND_MAX    = 16'd100
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        wr_stb,
    input  wire        rd_stb,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] wr_data,
    output reg  [15:0] rd_data_r,
    output reg         rd_ack_r,
    output reg         cmd_err_r,
    input  wire        out_above_pg_on,
    input  wire        sharing_cfg,
    input  wire        ramp_active,
    input  wire [13:0] fault_events,
    output wire [4:0]  min_on_code,
    output wire        min_duty_en,
    output wire        drive_en,
    output wire        power_good_pin_o,
    output wire        power_good_pin_oe_n,
    output wire        ext_temp_en,
    output wire        ext_temp_for_faults,
    output wire [4:0]  group_comm_bus_id,
    output wire [2:0]  phase_position,
    output wire [3:0]  phases_on_rail,
    output wire        phases_cfg_bad,
    output wire [7:0]  ramp_gain,
    output wire        shared_ramp_mode,
    output wire        fast_loop_en,
    output wire        soft_off_en,
    output wire [15:0] inductance,
    output reg         snapshot_trig_r
);

////////////////////////////////////////////////////////////////////////////////
reg [15:0] misc_r;
reg [15:0] group_r;
reg [15:0] okdly_r;
reg [7:0]  ramp_r;
reg [15:0] ind_r;
reg [15:0] snap_r;
reg        pg_r;
reg [15:0] ms_cnt_r;
reg [31:0] cyc_cnt_r;
reg [2:0]  sync_r;
reg        above_r;
wire       known;

assign known = (cmd_code == `PMCFG_CMD_MISC) || (cmd_code == `PMCFG_CMD_GROUP) ||
               (cmd_code == `PMCFG_CMD_OKDLY) || (cmd_code == `PMCFG_CMD_RAMP) ||
               (cmd_code == `PMCFG_CMD_IND) || (cmd_code == `PMCFG_CMD_SNAPMASK);

// register writes; reserved bits masked off so they always read zero
always @(posedge mclk) begin
    if (!rst_n) begin
        misc_r  <= `PMCFG_MISC_RST;
        group_r <= `PMCFG_GROUP_RST;
        okdly_r <= `PMCFG_OKDLY_RST;
        ramp_r  <= `PMCFG_RAMP_RST;
        ind_r   <= `PMCFG_IND_RST;
        snap_r  <= `PMCFG_SNAP_RST;
    end else if (wr_stb) begin
        case (cmd_code)
            `PMCFG_CMD_MISC:  misc_r <= wr_data & `PMCFG_MISC_WMASK;
            `PMCFG_CMD_GROUP: begin
                // odd field values (1,3,5,7) only, even phase counts; bad values are dropped, not stored
                if (wr_data[`PMCFG_NPH_LO] && (wr_data[`PMCFG_NPH_HI] == 1'b0)) begin
                    group_r <= wr_data & `PMCFG_GROUP_WMASK;
                end
            end
            `PMCFG_CMD_OKDLY: begin
                // beyond the documented span is clamped at the top
                if (wr_data > `PMCFG_OKDLY_MAX_MS) begin
                    okdly_r <= `PMCFG_OKDLY_MAX_MS;
                end else begin
                    okdly_r <= wr_data;
                end
            end
            `PMCFG_CMD_RAMP:  ramp_r <= wr_data[7:0];
            `PMCFG_CMD_IND: begin
                if (wr_data > IND_MAX) begin
                    ind_r <= IND_MAX;
                end else begin
                    ind_r <= wr_data;
                end
            end
            `PMCFG_CMD_SNAPMASK: snap_r <= wr_data & `PMCFG_SNAP_WMASK;
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path and unknown-command flag, one cycle after the strobe
always @(posedge mclk) begin
    if (!rst_n) begin
        rd_data_r <= 16'h0000;
        rd_ack_r  <= 1'b0;
        cmd_err_r <= 1'b0;
    end else begin
        rd_ack_r  <= rd_stb;
        cmd_err_r <= (rd_stb | wr_stb) & ~known;
        if (rd_stb) begin
            case (cmd_code)
                `PMCFG_CMD_MISC:     rd_data_r <= misc_r;
                `PMCFG_CMD_GROUP:    rd_data_r <= group_r;
                `PMCFG_CMD_OKDLY:    rd_data_r <= okdly_r;
                `PMCFG_CMD_RAMP:     rd_data_r <= {8'h00, ramp_r};
                `PMCFG_CMD_IND:      rd_data_r <= ind_r;
                `PMCFG_CMD_SNAPMASK: rd_data_r <= snap_r;
                default:             rd_data_r <= 16'h0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// threshold input comes from the analog side; 3 stages, agree on last two
always @(posedge mclk) begin
    if (!rst_n) begin
        sync_r  <= 3'b000;
        above_r <= 1'b0;
    end else begin
        sync_r <= {sync_r[1:0], out_above_pg_on};
        if (sync_r[2] == sync_r[1]) begin
            above_r <= sync_r[2];
        end
    end
end

// delay counted in whole ms; the register already holds integer ms
always @(posedge mclk) begin
    if (!rst_n) begin
        cyc_cnt_r <= 32'h00000000;
        ms_cnt_r  <= 16'h0000;
        pg_r      <= 1'b0;
    end else if (!above_r) begin
        cyc_cnt_r <= 32'h00000000;
        ms_cnt_r  <= 16'h0000;
        pg_r      <= 1'b0;
    end else if (!pg_r) begin
        if (ms_cnt_r >= okdly_r) begin
            pg_r <= 1'b1;
        end else if (cyc_cnt_r == CYC_PER_MS - 1) begin
            cyc_cnt_r <= 32'h00000000;
            ms_cnt_r  <= ms_cnt_r + 16'h0001;
        end else begin
            cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
        end
    end
end

// pin: open-drain releases for high, push-pull drives both levels
assign power_good_pin_o    = pg_r;
assign power_good_pin_oe_n = misc_r[`PMCFG_PG_PP_BIT] ? 1'b0 : pg_r;

////////////////////////////////////////////////////////////////////////////////
// field decode to the converter core
assign min_on_code         = misc_r[`PMCFG_MINDUTY_HI:`PMCFG_MINDUTY_LO];
assign min_duty_en         = misc_r[`PMCFG_MINDUTY_EN];
assign drive_en            = misc_r[`PMCFG_DRV_EN_BIT];
assign ext_temp_en         = misc_r[`PMCFG_XT_EN_BIT];
assign ext_temp_for_faults = misc_r[`PMCFG_XT_FLT_BIT];
assign group_comm_bus_id   = group_r[`PMCFG_RAIL_HI:`PMCFG_RAIL_LO];
assign phase_position      = {1'b0, group_r[14:13]} + 3'd1;
assign phases_on_rail      = group_r[`PMCFG_NPH_HI:`PMCFG_NPH_LO] + 4'd1;
assign phases_cfg_bad      = ~group_r[`PMCFG_NPH_LO] | group_r[`PMCFG_NPH_HI];
// core scales rise time inversely with this gain
assign ramp_gain           = ramp_r;
assign shared_ramp_mode    = sharing_cfg;
assign fast_loop_en        = ~(sharing_cfg & ramp_active & ~pg_r);
assign soft_off_en         = ~sharing_cfg;
assign inductance          = ind_r;

// snapshot request: any unmasked fault event
always @(posedge mclk) begin
    if (!rst_n) begin
        snapshot_trig_r <= 1'b0;
    end else begin
        snapshot_trig_r <= |(fault_events & ~snap_r[13:0]);
    end
end

endmodule // pmcfg_regs

//--- sim/pmcfg_chk.sv
`timescale 1ns/1ps
module pmcfg_chk (
    input logic        mclk, rst_n, wr_stb, sharing_cfg, ramp_active, out_above_pg_on,
    input logic [7:0]  cmd_code,
    input logic [15:0] wr_data,
    input logic        drive_en, min_duty_en, ext_temp_en, ext_temp_for_faults,
    input logic        power_good_pin_oe_n, phases_cfg_bad, shared_ramp_mode,
    input logic        soft_off_en, fast_loop_en, snapshot_trig_r,
    input logic [4:0]  min_on_code, group_comm_bus_id,
    input logic [2:0]  phase_position,
    input logic [3:0]  phases_on_rail,
    input logic [13:0] fault_events,
    input logic        rd_stb, rd_ack_r, cmd_err_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // setup word strobes; a malformed group word is dropped whole, so it is not counted
    wire misc_wr = wr_stb && cmd_code == 8'hD1;
    wire grp_wr  = wr_stb && cmd_code == 8'hD3 && wr_data[0] && !wr_data[3];
    ////////////////////////////////////////////////////////////////////////////////
    property p_misc; misc_wr |=> {min_on_code, min_duty_en, ext_temp_en, ext_temp_for_faults}
        == $past({wr_data[15:11], wr_data[7], wr_data[1:0]}); endproperty
    a_misc: assert property (p_misc) else $error("misc fields wrong");
    property p_drive; misc_wr |=> drive_en == $past(wr_data[10]); endproperty
    a_drive: assert property (p_drive) else $error("drive gate wrong");
    property p_pgpp; misc_wr && wr_data[2] |=> !power_good_pin_oe_n; endproperty
    a_pgpp: assert property (p_pgpp) else $error("push-pull not driven");
    property p_grp; grp_wr |=> group_comm_bus_id == $past(wr_data[12:8])
        && phase_position == $past(wr_data[14:13]) + 3'h1; endproperty
    a_grp: assert property (p_grp) else $error("group setup wrong");
    property p_nph; !phases_cfg_bad |-> phases_on_rail inside {4'h2, 4'h4, 4'h6, 4'h8}; endproperty
    a_nph: assert property (p_nph) else $error("phase count accepted");
    property p_share; sharing_cfg |-> shared_ramp_mode && !soft_off_en; endproperty
    a_share: assert property (p_share) else $error("sharing modes wrong");
    property p_fast; (sharing_cfg && ramp_active && !out_above_pg_on)[*6] |-> !fast_loop_en;
        endproperty
    a_fast: assert property (p_fast) else $error("fast loop on in ramp");
    property p_snap; fault_events == 14'h0000 |=> !snapshot_trig_r; endproperty
    a_snap: assert property (p_snap) else $error("snapshot without fault");
    property p_ack; rd_stb |=> rd_ack_r; endproperty
    a_ack: assert property (p_ack) else $error("read not acknowledged");
    property p_err; (rd_stb || wr_stb) && !(cmd_code inside {8'hD1, 8'hD3, 8'hD4, 8'hD5,
        8'hD6, 8'hD7}) |=> cmd_err_r; endproperty
    a_err: assert property (p_err) else $error("unknown code not flagged");
endmodule // pmcfg_chk

//--- sim/pmcfg_host.sv
`timescale 1ns/1ps
module pmcfg_host (
    input  logic        mclk,
    output logic        wr_stb,
    output logic        rd_stb,
    output logic [7:0]  cmd_code,
    output logic [15:0] wr_data,
    input  logic [15:0] rd_data_r
);
    // idle bus from time zero
    initial begin
        {wr_stb, rd_stb, cmd_code, wr_data} = 26'h0;
    end
    // data is inverted on release so a stale value can never be taken
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge mclk);
        {wr_stb, cmd_code, wr_data} <= {1'b1, c, d};
        @(posedge mclk);
        {wr_stb, wr_data} <= {1'b0, ~d};
    endtask
    // answer is latched one cycle after the strobe edge and held
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge mclk);
        {rd_stb, cmd_code} <= {1'b1, c};
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(posedge mclk);
        d = rd_data_r;
    endtask
endmodule // pmcfg_host

//--- sim/test_pol_misc_config_registers.sv
`timescale 1ns/1ps
module test_pol_misc_config_registers;
    logic mclk, rst_n, wr_stb, rd_stb, out_above_pg_on, sharing_cfg, ramp_active;
    logic drive_en, power_good_pin_o, power_good_pin_oe_n, snapshot_trig_r;
    logic [7:0] cmd_code;
    logic [13:0] fault_events;
    logic [15:0] wr_data, rd_data_r, rdv;
    int bad_count = 0, compares = 0, i, n;
    logic [7:0] codes [6] = '{8'hD1, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7};
    logic [15:0] rst_v [6] = '{16'h0400, 16'h0, 16'h0, 16'h0001, 16'h0, 16'h0};
    logic [15:0] all_v [6] = '{16'hFC87, 16'hFF07, 16'h1388, 16'h00F7, 16'h0064, 16'h3FF7};
    pmcfg_regs #(.CYC_PER_MS(10)) i_dut (.*, .rd_ack_r(), .cmd_err_r(), .min_on_code(),
        .min_duty_en(), .ext_temp_en(), .ext_temp_for_faults(), .group_comm_bus_id(),
        .phase_position(), .phases_on_rail(), .phases_cfg_bad(), .ramp_gain(),
        .shared_ramp_mode(), .fast_loop_en(), .soft_off_en(), .inductance());
    pmcfg_host i_host (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wrd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
        i_host.wr(c, d);
        i_host.rd(c, rdv);
        chk(rdv, e);
    endtask
    // reset values, full writes, refused group word, unknown code, clamps
    task automatic t_regs;
        for (i = 0; i < 6; i++) begin
            i_host.rd(codes[i], rdv);
            chk(rdv, rst_v[i]);
        end
        for (i = 0; i < 6; i++) wrd(codes[i], 16'hFFF7, all_v[i]);
        wrd(8'hD3, 16'h0008, 16'hFF07);
        wrd(8'hD2, 16'h1234, 16'h0000);
        wrd(8'hD4, 16'h1387, 16'h1387);
        wrd(8'hD6, 16'h0065, 16'h0064);
        i_host.wr(8'hD1, 16'h0000);
        @(negedge mclk);
        chk({15'h0, drive_en}, 16'h0000);
    endtask
    // delay is counted in ms after the level crosses; window allows the input sync
    task automatic t_pg(input logic [15:0] ms, input logic pp, input int lo, input int hi);
        i_host.wr(8'hD1, {5'h00, 1'b1, 7'h00, pp, 2'h0});
        i_host.wr(8'hD4, ms);
        out_above_pg_on <= 1'b1;
        for (n = 0; power_good_pin_o !== 1'b1 && n < 100; n++) @(negedge mclk);
        chk(16'(n >= lo && n <= hi), 16'h0001);
        chk({15'h0, power_good_pin_oe_n}, {15'h0, ~pp});
        @(posedge mclk);
        out_above_pg_on <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({15'h0, power_good_pin_o}, 16'h0000);
    endtask
    task automatic hit(input logic [13:0] ev, input logic exp);
        @(posedge mclk);
        fault_events <= ev;
        @(posedge mclk);
        fault_events <= 14'h0;
        @(negedge mclk);
        chk({15'h0, snapshot_trig_r}, {15'h0, exp});
    endtask
    // each mask bit must block exactly its own fault line
    task automatic t_snap;
        for (i = 0; i < 14; i++) begin
            i_host.wr(8'hD7, 16'h3FFF ^ (16'h1 << i));
            hit(14'h1 << i, 1'b0 + 1'b1);
            hit(14'h3FFF ^ (14'h1 << i), 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // watchdog: the whole run is far below this span
    initial begin
        #400000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {rst_n, out_above_pg_on, sharing_cfg, ramp_active, fault_events} = 18'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_pg(16'h0002, 1'b1, 21, 28);
        t_pg(16'h0000, 1'b0, 1, 8);
        t_snap;
        @(posedge mclk);
        {sharing_cfg, ramp_active} <= 2'h3;
        repeat (10) @(posedge mclk);
        print_verdict;
    end
endmodule // test_pol_misc_config_registers
bind pmcfg_regs pmcfg_chk i_chk (.*);
